// file: pkg/lsoc_pkg.sv
// Purpose: Constants and types of the limit switch output comparator
// Assumes: APB slave with 32-bit data, 12-bit byte address
// Notes:   Point registers sit in a window of 0x20 bytes per point
package lsoc_pkg;
	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int          NUM_POINTS   = 32;
	localparam int          NUM_OUTPUTS  = 32;
	localparam int          NUM_WATCH    = 8;
	localparam int          ADDR_W       = 12;
	localparam int          DATA_W       = 32;
	localparam int          VAL_W        = 64;
	localparam int          INT16_W      = 16;
	localparam int          INT32_W      = 32;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [11:0] CTRL_OFS     = 12'h000;
	localparam logic [11:0] STATUS_OFS   = 12'h004;
	localparam logic [11:0] OUTPUT_OFS   = 12'h008;
	localparam logic [11:0] HITS_OFS     = 12'h00C;
	localparam logic [1:0]  POINT_AREA   = 2'h1;
	localparam int          AREA_LSB     = 10;
	localparam int          POINT_LSB    = 5;
	localparam int          WORD_LSB     = 2;
	localparam logic [2:0]  PW_CFG       = 3'h0;
	localparam logic [2:0]  PW_ON_LO     = 3'h1;
	localparam logic [2:0]  PW_ON_HI     = 3'h2;
	localparam logic [2:0]  PW_OFF_LO    = 3'h3;
	localparam logic [2:0]  PW_OFF_HI    = 3'h4;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int          CTRL_HOST_BIT   = 0;
	localparam int          STAT_PROC_BIT   = 0;
	localparam int          STAT_HOST_BIT   = 1;
	localparam int          CFG_W           = 12;
	localparam logic [11:0] CFG_RESET       = 12'h000;
	localparam logic [63:0] THR_RESET       = 64'h0000000000000000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		LSOC_FMT_INT16 = 2'h0,
		LSOC_FMT_INT32 = 2'h1,
		LSOC_FMT_REAL64 = 2'h2
	} lsoc_fmt_t;

	typedef struct packed {
		logic      force_used;
		logic      enable_used;
		lsoc_fmt_t fmt;
		logic [2:0] watch_sel;
		logic [4:0] target;
	} lsoc_cfg_t;

	typedef struct packed {
		logic [63:0] on_value;
		logic [63:0] off_value;
	} lsoc_region_t;
endpackage

// file: core/lsoc_comparator.sv
// Purpose: Limit switch output comparator with APB register access
// Assumes: Watch values and op_tick come from logic on pclk
// Notes:   Enable and force bits arrive from outside and are synchronised
//
// Overview of operation
// - On below off: output high while on <= watch < off.
// - On above off: output high when watch >= on or watch < off.
// - On equal off: output low for every watch value.
// - Thresholds and watch value compare as signed numbers.
// - Outputs evaluated only while processor ready; ready follows host ready rise.
// - Host ready fall clears processor ready and drives all outputs low.
// - Thresholds captured at host ready rise, then re-read every operation cycle.
// - Up to 32 points; points may share watch values and targets.
// - Regions aimed at one output are ORed together.
// - Configured enable bit high applies comparison; low holds point low.
// - Point without configured enable bit is always enabled.
// - Configured force bit high drives point high, over a low enable.
// - Point without configured force bit is never forced.
// - Final results of all points on one output are ORed.
// - Watch values compare as 16-bit, 32-bit integer or 64-bit real.
// - Thresholds use the same format as the point's watch value.
//
// Added by the designer: the register offsets and the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module lsoc_comparator (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire logic                     clk_en,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic                     op_tick,
	input  wire logic [7:0][63:0]         watch_value,
	input  wire logic [31:0]              point_enable_bits,
	input  wire logic [31:0]              point_force_bits,
	output logic      [31:0]              limit_out,
	output logic                          motion_processor_ready
);

	// ----------------------------------------------------------------
	// Signed key of a value in the selected format
	// ----------------------------------------------------------------
	function automatic logic signed [63:0] to_key(input lsoc_pkg::lsoc_fmt_t fmt, input logic [63:0] v);
		logic signed [63:0] k;
		k = 64'sh0000000000000000;
		unique case (fmt)
			lsoc_pkg::LSOC_FMT_INT16: k = {{48{v[15]}}, v[15:0]};
			lsoc_pkg::LSOC_FMT_INT32: k = {{32{v[31]}}, v[31:0]};
			lsoc_pkg::LSOC_FMT_REAL64: k = v[63] ? -$signed({1'b0, v[62:0]}) : $signed({1'b0, v[62:0]});
			default: k = 64'sh0000000000000000;
		endcase
		return k;
	endfunction

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	lsoc_pkg::lsoc_cfg_t    cfg_sh_reg   [32];
	logic [63:0]            on_sh_reg    [32];
	logic [63:0]            off_sh_reg   [32];
	lsoc_pkg::lsoc_cfg_t    cfg_int_reg  [32];
	lsoc_pkg::lsoc_region_t reg_int_reg  [32];
	logic                   host_ready_flag_reg;
	logic                   motion_processor_ready_flag_reg;
	logic                   eval_reg;
	logic [31:0]            out_reg;
	logic [31:0]            hits_reg;
	logic [31:0]            en_meta_reg;
	logic [31:0]            en_sync_reg;
	logic [31:0]            frc_meta_reg;
	logic [31:0]            frc_sync_reg;
	logic                   rsp_reg;
	logic [31:0]            prdata_reg;
	logic                   pslverr_reg;
	logic [31:0]            rd_next;
	logic                   rd_err_next;
	logic [31:0]            hit_next;
	logic [31:0]            out_next;
	logic                   host_rise;
	logic                   capture;
	logic                   wr_do;
	logic                   in_points;
	logic [4:0]             pt_idx;
	logic [2:0]             pw_idx;

	// ----------------------------------------------------------------
	// Pin synchronisers for enable and force bits
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_meta_reg  <= 32'h00000000;
			en_sync_reg  <= 32'h00000000;
			frc_meta_reg <= 32'h00000000;
			frc_sync_reg <= 32'h00000000;
		end else if (clk_en) begin
			en_meta_reg  <= point_enable_bits;
			en_sync_reg  <= en_meta_reg;
			frc_meta_reg <= point_force_bits;
			frc_sync_reg <= frc_meta_reg;
		end
	end

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	assign in_points = (paddr[11:lsoc_pkg::AREA_LSB] == lsoc_pkg::POINT_AREA);
	assign pt_idx    = paddr[9:lsoc_pkg::POINT_LSB];
	assign pw_idx    = paddr[4:lsoc_pkg::WORD_LSB];
	assign pready    = rsp_reg & clk_en;
	assign prdata    = prdata_reg;
	assign pslverr   = pslverr_reg;
	assign wr_do     = psel & penable & pwrite & pready & ~pslverr_reg;

	always_comb begin
		rd_next     = 32'h00000000;
		rd_err_next = 1'b0;
		if (in_points) begin
			unique case (pw_idx)
				lsoc_pkg::PW_CFG:    rd_next = {20'h00000, cfg_sh_reg[pt_idx]};
				lsoc_pkg::PW_ON_LO:  rd_next = on_sh_reg[pt_idx][31:0];
				lsoc_pkg::PW_ON_HI:  rd_next = on_sh_reg[pt_idx][63:32];
				lsoc_pkg::PW_OFF_LO: rd_next = off_sh_reg[pt_idx][31:0];
				lsoc_pkg::PW_OFF_HI: rd_next = off_sh_reg[pt_idx][63:32];
				default:             rd_err_next = 1'b1;
			endcase
		end else begin
			unique case (paddr)
				lsoc_pkg::CTRL_OFS:   rd_next[lsoc_pkg::CTRL_HOST_BIT] = host_ready_flag_reg;
				lsoc_pkg::STATUS_OFS: begin
					rd_next[lsoc_pkg::STAT_PROC_BIT] = motion_processor_ready_flag_reg;
					rd_next[lsoc_pkg::STAT_HOST_BIT] = host_ready_flag_reg;
				end
				lsoc_pkg::OUTPUT_OFS: rd_next = out_reg;
				lsoc_pkg::HITS_OFS:   rd_next = hits_reg;
				default:              rd_err_next = 1'b1;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// One wait state: answer registered in first access cycle
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rsp_reg     <= 1'b0;
			prdata_reg  <= 32'h00000000;
			pslverr_reg <= 1'b0;
		end else if (clk_en) begin
			if (psel && penable && !rsp_reg) begin
				rsp_reg     <= 1'b1;
				prdata_reg  <= pwrite ? 32'h00000000 : rd_next;
				pslverr_reg <= rd_err_next;
			end else begin
				rsp_reg     <= 1'b0;
				pslverr_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Host ready flag written by software
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			host_ready_flag_reg <= 1'b0;
		end else if (clk_en && wr_do && !in_points && paddr == lsoc_pkg::CTRL_OFS) begin
			host_ready_flag_reg <= pwdata[lsoc_pkg::CTRL_HOST_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Software-side point settings (word storage)
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < lsoc_pkg::NUM_POINTS; i++) begin
				cfg_sh_reg[i] <= lsoc_pkg::CFG_RESET;
				on_sh_reg[i]  <= lsoc_pkg::THR_RESET;
				off_sh_reg[i] <= lsoc_pkg::THR_RESET;
			end
		end else if (clk_en && wr_do && in_points) begin
			unique case (pw_idx)
				lsoc_pkg::PW_CFG:    cfg_sh_reg[pt_idx]        <= pwdata[lsoc_pkg::CFG_W-1:0];
				lsoc_pkg::PW_ON_LO:  on_sh_reg[pt_idx][31:0]   <= pwdata;
				lsoc_pkg::PW_ON_HI:  on_sh_reg[pt_idx][63:32]  <= pwdata;
				lsoc_pkg::PW_OFF_LO: off_sh_reg[pt_idx][31:0]  <= pwdata;
				lsoc_pkg::PW_OFF_HI: off_sh_reg[pt_idx][63:32] <= pwdata;
				default:             ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Ready sequencing
	// ----------------------------------------------------------------
	assign host_rise = host_ready_flag_reg & ~motion_processor_ready_flag_reg;
	assign capture   = host_rise | (motion_processor_ready_flag_reg & op_tick);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			motion_processor_ready_flag_reg <= 1'b0;
		end else if (clk_en) begin
			motion_processor_ready_flag_reg <= host_ready_flag_reg;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			eval_reg <= 1'b0;
		end else if (clk_en) begin
			eval_reg <= motion_processor_ready_flag_reg & host_ready_flag_reg & op_tick;
		end
	end

	// ----------------------------------------------------------------
	// Per point capture and region logic
	// ----------------------------------------------------------------
	for (genvar p = 0; p < lsoc_pkg::NUM_POINTS; p++) begin : g_point
		logic signed [63:0] w_key;
		logic signed [63:0] on_key;
		logic signed [63:0] off_key;
		logic               region;
		logic               enabled;
		logic               forced;

		// ------------------------------------------------------------
		// Capture of settings
		// ------------------------------------------------------------
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				cfg_int_reg[p] <= lsoc_pkg::CFG_RESET;
				reg_int_reg[p] <= {lsoc_pkg::THR_RESET, lsoc_pkg::THR_RESET};
			end else if (clk_en && capture) begin
				cfg_int_reg[p] <= cfg_sh_reg[p];
				reg_int_reg[p] <= {on_sh_reg[p], off_sh_reg[p]};
			end
		end

		// Shared watch channels per point, thresholds in same format
		assign w_key   = to_key(cfg_int_reg[p].fmt, watch_value[cfg_int_reg[p].watch_sel]);
		assign on_key  = to_key(cfg_int_reg[p].fmt, reg_int_reg[p].on_value);
		assign off_key = to_key(cfg_int_reg[p].fmt, reg_int_reg[p].off_value);

		// ------------------------------------------------------------
		// Region of one point
		// ------------------------------------------------------------
		always_comb begin
			if (on_key < off_key) begin
				region = (w_key >= on_key) && (w_key < off_key);
			end else if (on_key > off_key) begin
				region = (w_key >= on_key) || (w_key < off_key);
			end else begin
				region = 1'b0;
			end
		end

		// ------------------------------------------------------------
		// Final result of one point
		// ------------------------------------------------------------
		assign enabled     = ~cfg_int_reg[p].enable_used | en_sync_reg[p];
		assign forced      = cfg_int_reg[p].force_used & frc_sync_reg[p];
		assign hit_next[p] = forced | (enabled & region);
	end

	// ----------------------------------------------------------------
	// Merge points onto outputs
	// ----------------------------------------------------------------
	for (genvar o = 0; o < lsoc_pkg::NUM_OUTPUTS; o++) begin : g_output
		logic [31:0] aimed;
		for (genvar q = 0; q < lsoc_pkg::NUM_POINTS; q++) begin : g_aim
			assign aimed[q] = (cfg_int_reg[q].target == 5'(o));
		end
		assign out_next[o] = |(aimed & hit_next);
	end

	// ----------------------------------------------------------------
	// Output register, cleared while not ready
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_reg  <= 32'h00000000;
			hits_reg <= 32'h00000000;
		end else if (clk_en) begin
			if (!motion_processor_ready_flag_reg || !host_ready_flag_reg) begin
				out_reg  <= 32'h00000000;
				hits_reg <= 32'h00000000;
			end else if (eval_reg) begin
				out_reg  <= out_next;
				hits_reg <= hit_next;
			end
		end
	end

	// ----------------------------------------------------------------
	// Pin outputs
	// ----------------------------------------------------------------
	assign limit_out              = out_reg;
	assign motion_processor_ready = motion_processor_ready_flag_reg;

endmodule // lsoc_comparator
`default_nettype wire

// file: test/lsoc_sva.sv
// Purpose: Port assertions for the limit switch comparator
// Assumes: clk_en held high
// Notes:   Bound to every comparator instance
`timescale 1ns/10ps
`default_nettype none
module lsoc_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        op_tick,
	input wire logic [31:0] limit_out,
	input wire logic        motion_processor_ready
);
	wire logic wr_ctrl;
	assign wr_ctrl = psel && penable && pready && pwrite && paddr == lsoc_pkg::CTRL_OFS;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_OFF_NOT_READY: assert property (!motion_processor_ready |-> limit_out == '0)
		else $error("outputs high while not ready");
	AST_TICK_UPDATE: assert property ($changed(limit_out) |-> $past(op_tick, 2) || !motion_processor_ready)
		else $error("outputs changed off the tick");
	AST_READY_RISE: assert property (wr_ctrl && pwdata[0] && !motion_processor_ready
		|-> ##[1:2] motion_processor_ready)
		else $error("ready did not follow host ready");
	AST_READY_FALL: assert property (wr_ctrl && !pwdata[0]
		|-> ##[1:2] (!motion_processor_ready && limit_out == '0))
		else $error("outputs not cleared on host ready fall");
	AST_ONE_WAIT: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
		else $error("access not one wait state");
	AST_ERR_WITH_READY: assert property (pslverr |-> pready)
		else $error("error without ready");
	AST_RSVD_ERR: assert property (psel && penable && pready && paddr[11:10] == 2'h1 && paddr[4:2] > 3'h4
		|-> pslverr)
		else $error("reserved word gave no error");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready held two cycles");
endmodule // lsoc_sva
bind lsoc_comparator lsoc_sva u_lsoc_sva (.*);
`default_nettype wire

// file: test/lsoc_motion_model.sv
// Purpose: Far side model: watch data, tick, bit devices
// Assumes: Tick every TICK_PERIOD cycles
// Notes:   Channels 4 to 7 carry a changing pattern
`timescale 1ns/10ps
`default_nettype none
module lsoc_motion_model #(
	parameter int TICK_PERIOD = 8
) (
	input  wire logic            pclk,
	input  wire logic            presetn,
	output var logic             op_tick,
	output var logic [7:0][63:0] watch_value,
	output var logic [31:0]      point_enable_bits,
	output var logic [31:0]      point_force_bits
);
	int               tick_cnt;
	logic [3:0][63:0] ld_v  = '0;
	logic [31:0]      ld_en = '0;
	logic [31:0]      ld_fo = '0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt <= 0;
			op_tick <= 1'b0;
			watch_value <= '0;
			point_enable_bits <= '0;
			point_force_bits <= '0;
		end else begin
			tick_cnt <= (tick_cnt == TICK_PERIOD - 1) ? 0 : tick_cnt + 1;
			op_tick <= (tick_cnt == 0);
			watch_value <= {~watch_value[7:4], ld_v};
			point_enable_bits <= ld_en;
			point_force_bits <= ld_fo;
		end
	end
	// One aligned 64-bit channel per watch value
	task automatic load(input logic [63:0] v[4], input logic [31:0] en, input logic [31:0] fo);
		ld_v <= {v[3], v[2], v[1], v[0]};
		ld_en <= en;
		ld_fo <= fo;
	endtask
endmodule // lsoc_motion_model
`default_nettype wire

// file: test/testbench.sv
// Purpose: Self-checking bench of the limit switch comparator
// Assumes: APB master tasks, far side model
// Notes:   Expected outputs computed from the point table
`timescale 1ns/10ps
`default_nettype none
module testbench;
	logic              pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr;
	logic              op_tick, motion_processor_ready, er;
	logic [11:0]       paddr;
	logic [31:0]       pwdata, prdata, point_enable_bits, point_force_bits, limit_out, rd;
	logic [7:0][63:0]  watch_value;
	lsoc_pkg::lsoc_cfg_t cfg_v[9];
	logic [63:0]       on_v[9], off_v[9];
	int                bad_count, cmp_count;
	logic [63:0] vec[6][4] = '{
		'{64'h5A5A5A5A0000000A, 64'h96, 64'hABCD00001234FFFC, 64'h4000000000000000},
		'{64'h13, 64'h63, 64'h5, 64'hC000000000000000},
		'{64'h14, 64'hC8, 64'hFFFFFFFFFFFFFFFB, 64'h3FF0000000000000},
		'{64'hFFFFFFF6, 64'h64, 64'h7FFF, 64'h4008000000000000},
		'{64'hFFFFFFF5, 64'hFFFFFFFF, 64'h4, 64'h0},
		'{64'hF, 64'h0, 64'hFFFA, 64'h8000000000000000}};
	lsoc_comparator u_lsoc_comparator (.*);
	lsoc_motion_model u_lsoc_motion_model (.*);
	always #10 pclk = ~pclk;
	task automatic give_verdict;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			n++;
			@(posedge pclk);
		end
		check(n, 32'h1, "bus wait states");
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic set_pt(input int p, input lsoc_pkg::lsoc_cfg_t c, input logic [63:0] on, input logic [63:0] off);
		logic [31:0] w[5];
		cfg_v[p] = c;
		on_v[p] = on;
		off_v[p] = off;
		w = '{{20'h0, c}, on[31:0], on[63:32], off[31:0], off[63:32]};
		for (int k = 0; k < 5; k++)
			apb(1'b1, 12'h400 + 12'(p * 32 + k * 4), w[k]);
	endtask
	function automatic logic hit(input real w, input real a, input real b);
		return (a < b) ? (a <= w && w < b) : (a > b && (w >= a || w < b));
	endfunction
	function automatic logic [31:0] exp_hits(input logic [63:0] v[4], input logic [31:0] en, input logic [31:0] fo);
		logic [31:0] o;
		logic [63:0] x;
		logic        h;
		o = '0;
		for (int p = 0; p < 9; p++) begin
			x = v[int'(cfg_v[p].watch_sel)];
			if (cfg_v[p].fmt == lsoc_pkg::LSOC_FMT_REAL64)
				h = hit($bitstoreal(x), $bitstoreal(on_v[p]), $bitstoreal(off_v[p]));
			else if (cfg_v[p].fmt == lsoc_pkg::LSOC_FMT_INT16)
				h = hit($signed(x[15:0]), $signed(on_v[p][15:0]), $signed(off_v[p][15:0]));
			else
				h = hit($signed(x[31:0]), $signed(on_v[p][31:0]), $signed(off_v[p][31:0]));
			o[p] = (cfg_v[p].force_used && fo[p]) || (h && (!cfg_v[p].enable_used || en[p]));
		end
		return o;
	endfunction
	function automatic logic [31:0] exp_out(input logic [31:0] hs);
		logic [31:0] o;
		o = '0;
		for (int p = 0; p < 9; p++)
			o[cfg_v[p].target] |= hs[p];
		return o;
	endfunction
	task automatic run_vec(input int i, input logic rdy);
		logic [31:0] en, fo, hs;
		en = i[0] ? 32'h20 : 32'h0;
		fo = i[1] ? 32'h40 : 32'h0;
		hs = rdy ? exp_hits(vec[i], en, fo) : 32'h0;
		u_lsoc_motion_model.load(vec[i], en, fo);
		repeat (24) @(posedge pclk);
		apb(1'b0, lsoc_pkg::OUTPUT_OFS, 32'h0);
		check(rd, exp_out(hs), "limit outputs");
		check(limit_out, exp_out(hs), "limit pins");
		check({31'h0, motion_processor_ready}, {31'h0, rdy}, "processor ready");
		apb(1'b0, lsoc_pkg::HITS_OFS, 32'h0);
		check(rd, hs, "point results");
	endtask
	initial begin
		{pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		clk_en = 1'b1;
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, lsoc_pkg::STATUS_OFS, 32'h0);
		check(rd, 32'h0, "status after reset");
		$display("test reset done");
		set_pt(0, '{1'b0, 1'b0, lsoc_pkg::LSOC_FMT_INT32, 3'h0, 5'h00}, 64'hA, 64'h14);
		set_pt(1, '{1'b0, 1'b0, lsoc_pkg::LSOC_FMT_INT32, 3'h0, 5'h01}, 64'h14, 64'hFFFFFFFFFFFFFFF6);
		set_pt(2, '{1'b0, 1'b0, lsoc_pkg::LSOC_FMT_INT32, 3'h0, 5'h02}, 64'hF, 64'hF);
		set_pt(3, '{1'b0, 1'b0, lsoc_pkg::LSOC_FMT_INT32, 3'h0, 5'h03}, 64'h0, 64'hC);
		set_pt(4, '{1'b0, 1'b0, lsoc_pkg::LSOC_FMT_INT32, 3'h1, 5'h03}, 64'h64, 64'hC8);
		set_pt(5, '{1'b0, 1'b1, lsoc_pkg::LSOC_FMT_INT32, 3'h0, 5'h04}, 64'hFFFFFFFFFFFFFF9C, 64'h64);
		set_pt(6, '{1'b1, 1'b1, lsoc_pkg::LSOC_FMT_INT32, 3'h0, 5'h05}, 64'h3E8, 64'h7D0);
		set_pt(7, '{1'b0, 1'b0, lsoc_pkg::LSOC_FMT_INT16, 3'h2, 5'h06}, 64'hFFFB, 64'h5);
		set_pt(8, '{1'b0, 1'b0, lsoc_pkg::LSOC_FMT_REAL64, 3'h3, 5'h07}, 64'h3FF0000000000000, 64'h4008000000000000);
		apb(1'b0, 12'h414, 32'h0);
		check({31'h0, er}, 32'h1, "reserved word error");
		run_vec(0, 1'b0);
		$display("test idle done");
		apb(1'b1, lsoc_pkg::CTRL_OFS, 32'h1);
		apb(1'b0, lsoc_pkg::STATUS_OFS, 32'h0);
		check(rd, 32'h3, "status ready");
		for (int i = 0; i < 6; i++)
			run_vec(i, 1'b1);
		$display("test regions done");
		set_pt(0, '{1'b0, 1'b0, lsoc_pkg::LSOC_FMT_INT32, 3'h0, 5'h00}, 64'hFFFFFFFFFFFFFFCE, 64'h14);
		run_vec(4, 1'b1);
		$display("test reload done");
		apb(1'b1, lsoc_pkg::CTRL_OFS, 32'h0);
		apb(1'b0, lsoc_pkg::OUTPUT_OFS, 32'h0);
		check(rd, 32'h0, "outputs after host ready fall");
		check(limit_out, 32'h0, "pins after host ready fall");
		check({31'h0, motion_processor_ready}, 32'h0, "ready after host ready fall");
		$display("test clear done");
		give_verdict();
	end
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		give_verdict();
	end
endmodule // testbench
`default_nettype wire
